// >>> hw/adcs_pkg.sv
// adcs_pkg: constants, codes and decode functions of the converter control block
// Operation
// [RQ1] input select 0000, 0100, 1100-1111 routes the chosen external pin
// [RQ2] input select 0001-0011 and 0101-0111 choose an internal signal
// [RQ3] internal signal selected: every external pin switch is open
// [RQ4] channel 0000, 0001, 0011-1000 map to pins 0, 1, 3-8
// [RQ5] channel 0010 and 1001-1111 connect no pin, input floats
// [RQ6] codes 0001, 0010, 0011 give supply, supply/2, supply/4
// [RQ7] codes 0101, 0110, 0111 give amplifier output, /2, /4
// [RQ8] input select 10xx grounds the converter input
// [RQ9] per-pin function bits choose analog input or other function anytime
// [RQ10] analog pin: all other pin functions disabled
// [RQ11] analog pin: register-enabled pull-high is disconnected
// [RQ12] analog pin: port direction setting is overridden
// [RQ13] software starts a conversion with a start pulse high then low
// [RQ14] busy set once conversion starts, cleared when it completes
// [RQ15] completion sets request flag and raises interrupt when enabled
// [RQ16] with interrupt disabled software may poll busy instead
// [RQ17] conversion clock is system clock divided by two to the select
// [RQ18] software keeps conversion clock period within 0.5 to 10 us
// [RQ19] converter stays powered down unless the enable bit is high
// [RQ20] software waits a settling delay after enabling before starting
// [RQ21] software should clear enable when no conversions are needed
// [RQ22] a conversion takes 4 sampling plus 12 converting clock periods
// [RQ23] result left-justified with format 0, right-justified with format 1
// [RQ24] result registers keep their contents while converter is disabled
// [RQ25] converter held in reset while start high, begins on its fall
package adcs_pkg;

    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 32;
    localparam int NUM_PINS = 9;
    localparam int RES_W    = 12;
    localparam int DIV_W    = 7;
    localparam int CNT_W    = 4;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL0   = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL1   = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_RES_HI  = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_RES_LO  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_PIN_LO  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_PIN_HI  = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ     = 5'h18;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int C0_START   = 7;
    localparam int C0_BUSY    = 6;
    localparam int C0_PWR     = 5;
    localparam int C0_FMT     = 4;
    localparam int C0_CH_LSB  = 0;
    localparam int C1_SIG_LSB = 4;
    localparam int C1_DIV_LSB = 0;
    localparam int IRQ_FLAG   = 0;
    localparam int IRQ_EN     = 1;

    localparam logic [3:0]          RST_NIBBLE = 4'h0;
    localparam logic [2:0]          RST_DIV    = 3'h0;
    localparam logic [NUM_PINS-1:0] RST_PINS   = 9'h000;
    localparam logic [7:0]          RST_BYTE   = 8'h00;
    localparam logic [DATA_W-1:0]   RD_ZERO    = 32'h0000_0000;

    // ****************************************************************
    // conversion timing in conversion clock periods
    // ****************************************************************
    localparam logic [CNT_W-1:0] SAMPLE_LAST = 4'h3;
    localparam logic [CNT_W-1:0] CONV_LAST   = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
    localparam logic [DIV_W-1:0] DIV_ONE     = 7'h01;
    localparam logic [DIV_W-1:0] DIV_ZERO    = 7'h00;

    typedef enum logic [2:0] {
        SRC_EXT    = 3'b000,
        SRC_CONVERTER_SUPPLY_VOLTAGE   = 3'b001,
        SRC_CONVERTER_SUPPLY_VOLTAGE_2 = 3'b010,
        SRC_CONVERTER_SUPPLY_VOLTAGE_4 = 3'b011,
        SRC_GND    = 3'b100,
        SRC_VVR    = 3'b101,
        SRC_VVR_2  = 3'b110,
        SRC_VVR_4  = 3'b111
    } adcs_src_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARM     = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_CONVERT = 2'b11
    } adcs_state_t;

    // input select code to analog source
    function automatic adcs_src_t decode_src(input logic [3:0] sel);
        case (sel)
            4'h1:    decode_src = SRC_CONVERTER_SUPPLY_VOLTAGE;   // RQ6
            4'h2:    decode_src = SRC_CONVERTER_SUPPLY_VOLTAGE_2; // RQ6
            4'h3:    decode_src = SRC_CONVERTER_SUPPLY_VOLTAGE_4; // RQ6
            4'h5:    decode_src = SRC_VVR;    // RQ7
            4'h6:    decode_src = SRC_VVR_2;  // RQ7
            4'h7:    decode_src = SRC_VVR_4;  // RQ7
            4'h8,
            4'h9,
            4'hA,
            4'hB:    decode_src = SRC_GND;    // RQ8
            default: decode_src = SRC_EXT;    // RQ1
        endcase
    endfunction

    // channel code to one-hot pin switch, zero means floating
    function automatic logic [NUM_PINS-1:0] decode_pin(input logic [3:0] ch);
        case (ch)
            4'h0:    decode_pin = 9'h001; // RQ4
            4'h1:    decode_pin = 9'h002; // RQ4
            4'h3:    decode_pin = 9'h008; // RQ4
            4'h4:    decode_pin = 9'h010; // RQ4
            4'h5:    decode_pin = 9'h020; // RQ4
            4'h6:    decode_pin = 9'h040; // RQ4
            4'h7:    decode_pin = 9'h080; // RQ4
            4'h8:    decode_pin = 9'h100; // RQ4
            default: decode_pin = 9'h000; // RQ5
        endcase
    endfunction

    // divide by two to the select: terminal count of the prescaler
    function automatic logic [DIV_W-1:0] div_last(input logic [2:0] sel);
        div_last = DIV_W'((DIV_ONE << sel) - DIV_ONE); // RQ17
    endfunction

endpackage

// >>> hw/adcs_clk_div.sv
// adcs_clk_div: conversion clock tick from the system clock
`timescale 1ns/1ps
module adcs_clk_div
    import adcs_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        run_i,
    input  wire logic [2:0]  div_sel_i,
    output logic             tick_o
);

    logic [DIV_W-1:0] count;
    wire              wrap = (count >= div_last(div_sel_i)); // RQ17

    // ****************************************************************
    // prescaler, cleared while idle so each conversion starts aligned
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count  <= DIV_ZERO;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            count  <= DIV_ZERO;
            tick_o <= 1'b0;
        end else begin
            count  <= wrap ? DIV_ZERO : DIV_W'(count + DIV_ONE);
            tick_o <= wrap;
        end
    end

endmodule

// >>> hw/adcs_top.sv
// adcs_top: input select, pin override and conversion sequencer with Avalon-MM slave
`timescale 1ns/1ps
module adcs_top
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_b_i,
    // register bus
    input  wire logic [adcs_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [adcs_pkg::DATA_W-1:0]   avs_writedata_i,
    output logic      [adcs_pkg::DATA_W-1:0]   avs_readdata_o,
    output logic                               avs_waitrequest_o,
    // port settings made elsewhere
    input  wire logic [adcs_pkg::NUM_PINS-1:0] port_dir_out_i,
    input  wire logic [adcs_pkg::NUM_PINS-1:0] port_pullup_i,
    // converter core
    input  wire logic [adcs_pkg::RES_W-1:0]    core_result_i,
    output logic                               adc_power_o,
    output logic                               core_reset_o,
    output logic                               core_sample_o,
    output logic                               core_conv_clk_o,
    output adcs_pkg::adcs_src_t                mux_src_o,
    output logic      [adcs_pkg::NUM_PINS-1:0] mux_ext_pin_o,
    // pad control
    output logic      [adcs_pkg::NUM_PINS-1:0] pin_analog_o,
    output logic      [adcs_pkg::NUM_PINS-1:0] pin_alt_en_o,
    output logic      [adcs_pkg::NUM_PINS-1:0] pin_gpio_en_o,
    output logic      [adcs_pkg::NUM_PINS-1:0] pin_pullup_en_o,
    output logic      [adcs_pkg::NUM_PINS-1:0] pin_oe_b_o,
    // interrupt request
    output logic                               adc_irq_o
);

    import adcs_pkg::*;

    // ********************************
    // register state
    // ********************************
    logic                start_bit;
    logic                power_enable;
    logic                result_format_select;
    logic [3:0]          external_channel_select;
    logic [3:0]          input_signal_select;
    logic [2:0]          conversion_clock_divider_select;
    logic [NUM_PINS-1:0] pin_function_select_lo;
    logic [NUM_PINS-1:0] pin_function_select_hi;
    logic [7:0]          result_high_byte;
    logic [7:0]          result_low_byte;
    logic                irq_flag;
    logic                irq_enable;
    logic                conversion_busy_flag;

    adcs_state_t         state;
    adcs_state_t         next_state;
    logic [CNT_W-1:0]    tick_count;
    logic [CNT_W-1:0]    next_tick_count;
    logic                conv_tick;
    logic                wait_q;

    // ********************************
    // bus decode
    // ********************************
    wire        wr_take   = avs_write_i && !wait_q;
    wire        rd_early  = avs_read_i && wait_q;
    wire        hit_ctrl0 = (avs_address_i == OFS_CTRL0);
    wire        hit_ctrl1 = (avs_address_i == OFS_CTRL1);
    wire        hit_reshi = (avs_address_i == OFS_RES_HI);
    wire        hit_reslo = (avs_address_i == OFS_RES_LO);
    wire        hit_pinlo = (avs_address_i == OFS_PIN_LO);
    wire        hit_pinhi = (avs_address_i == OFS_PIN_HI);
    wire        hit_irq   = (avs_address_i == OFS_IRQ);
    wire        wr_ctrl0  = wr_take && hit_ctrl0;
    wire        wr_ctrl1  = wr_take && hit_ctrl1;
    wire        wr_pinlo  = wr_take && hit_pinlo;
    wire        wr_pinhi  = wr_take && hit_pinhi;
    wire        wr_irq    = wr_take && hit_irq;
    wire        wd_start  = avs_writedata_i[C0_START];
    wire        start_set = wr_ctrl0 && wd_start;
    wire        start_end = wr_ctrl0 && !wd_start && start_bit;

    wire [7:0]  ctrl0_rd  = {start_bit, conversion_busy_flag, power_enable,
                             result_format_select, external_channel_select};
    wire [7:0]  ctrl1_rd  = {input_signal_select, 1'b0, conversion_clock_divider_select};
    wire [1:0]  irq_rd    = {irq_enable, irq_flag};

    wire [DATA_W-1:0] rd_word =
        hit_ctrl0 ? DATA_W'(ctrl0_rd) :
        hit_ctrl1 ? DATA_W'(ctrl1_rd) :
        hit_reshi ? DATA_W'(result_high_byte) :
        hit_reslo ? DATA_W'(result_low_byte) :
        hit_pinlo ? DATA_W'(pin_function_select_lo) :
        hit_pinhi ? DATA_W'(pin_function_select_hi) :
        hit_irq   ? DATA_W'(irq_rd) :
                    RD_ZERO;

    // ********************************
    // sequencer decode
    // ********************************
    wire        last_tick = conv_tick && (tick_count == CONV_LAST);
    wire        conv_done = (state == ST_CONVERT) && last_tick && power_enable
                            && !start_set;
    wire [RES_W-1:0] res  = core_result_i;
    wire [7:0]  fmt_hi    = result_format_select ? {4'h0, res[11:8]} : res[11:4];
    wire [7:0]  fmt_lo    = result_format_select ? res[7:0] : {res[3:0], 4'h0};

    // ********************************
    // analog input select and pin override decode
    // ********************************
    wire adcs_src_t      src_dec = decode_src(input_signal_select);
    wire [NUM_PINS-1:0]  ext_dec = (src_dec == SRC_EXT) ?
                                   decode_pin(external_channel_select) : // RQ1
                                   RST_PINS;                             // RQ3
    wire [NUM_PINS-1:0]  analog  = pin_function_select_lo;               // RQ9
    wire [NUM_PINS-1:0]  alt_dec = ~analog & pin_function_select_hi;     // RQ10
    wire [NUM_PINS-1:0]  gpio_dec = ~analog & ~pin_function_select_hi;   // RQ10
    wire [NUM_PINS-1:0]  pull_dec = ~analog & port_pullup_i;             // RQ11
    wire [NUM_PINS-1:0]  oe_b_dec = analog | ~port_dir_out_i;            // RQ12

    // ********************************
    // sequencer next state
    // ********************************
    always_comb begin
        next_state      = state;
        next_tick_count = tick_count;
        case (state)
            ST_IDLE: begin
                next_tick_count = CNT_ZERO;
                if (start_set) begin
                    next_state = ST_ARM; // RQ25
                end
            end
            ST_ARM: begin
                next_tick_count = CNT_ZERO;
                if (start_end) begin
                    next_state = power_enable ? ST_SAMPLE : ST_IDLE; // RQ25
                end
            end
            ST_SAMPLE: begin
                if (start_set) begin
                    next_state = ST_ARM;
                end else if (!power_enable) begin
                    next_state = ST_IDLE; // RQ19
                end else if (conv_tick) begin
                    next_tick_count = CNT_W'(tick_count + CNT_ONE);
                    if (tick_count == SAMPLE_LAST) begin
                        next_state = ST_CONVERT; // RQ22
                    end
                end
            end
            ST_CONVERT: begin
                if (start_set) begin
                    next_state = ST_ARM;
                end else if (!power_enable) begin
                    next_state = ST_IDLE; // RQ19
                end else if (conv_tick) begin
                    next_tick_count = CNT_W'(tick_count + CNT_ONE);
                    if (last_tick) begin
                        next_state = ST_IDLE; // RQ22
                    end
                end
            end
            default: begin
                next_state      = ST_IDLE;
                next_tick_count = CNT_ZERO;
            end
        endcase
    end

    wire next_running = (next_state == ST_SAMPLE) || (next_state == ST_CONVERT);

    // ********************************
    // conversion clock
    // ********************************
    adcs_clk_div u_clk_div (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .run_i     (next_running),
        .div_sel_i (conversion_clock_divider_select),
        .tick_o    (conv_tick)
    );

    // ********************************
    // bus handshake: one wait state on every access
    // ********************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_q         <= 1'b1;
            avs_readdata_o <= RD_ZERO;
        end else begin
            wait_q <= !((avs_read_i || avs_write_i) && wait_q);
            if (rd_early) begin
                avs_readdata_o <= rd_word;
            end
        end
    end

    assign avs_waitrequest_o = wait_q;

    // ********************************
    // control registers
    // ********************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_bit               <= 1'b0;
            power_enable            <= 1'b0;
            result_format_select    <= 1'b0;
            external_channel_select <= RST_NIBBLE;
        end else if (wr_ctrl0) begin
            start_bit               <= wd_start; // RQ13
            power_enable            <= avs_writedata_i[C0_PWR];
            result_format_select    <= avs_writedata_i[C0_FMT];
            external_channel_select <= avs_writedata_i[C0_CH_LSB +: 4];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            input_signal_select             <= RST_NIBBLE;
            conversion_clock_divider_select <= RST_DIV;
        end else if (wr_ctrl1) begin
            input_signal_select             <= avs_writedata_i[C1_SIG_LSB +: 4];
            conversion_clock_divider_select <= avs_writedata_i[C1_DIV_LSB +: 3];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_function_select_lo <= RST_PINS;
            pin_function_select_hi <= RST_PINS;
        end else begin
            if (wr_pinlo) begin
                pin_function_select_lo <= avs_writedata_i[NUM_PINS-1:0]; // RQ9
            end
            if (wr_pinhi) begin
                pin_function_select_hi <= avs_writedata_i[NUM_PINS-1:0];
            end
        end
    end

    // ********************************
    // interrupt request: completion beats a same-cycle clear
    // ********************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_flag   <= 1'b0;
            irq_enable <= 1'b0;
            adc_irq_o  <= 1'b0;
        end else begin
            if (conv_done) begin
                irq_flag <= 1'b1; // RQ15
            end else if (wr_irq && avs_writedata_i[IRQ_FLAG]) begin
                irq_flag <= 1'b0;
            end
            if (wr_irq) begin
                irq_enable <= avs_writedata_i[IRQ_EN];
            end
            adc_irq_o <= (irq_flag || conv_done) && irq_enable; // RQ15
        end
    end

    // ********************************
    // sequencer and result
    // ********************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state                <= ST_IDLE;
            tick_count           <= CNT_ZERO;
            conversion_busy_flag <= 1'b0;
            core_reset_o         <= 1'b0;
            core_sample_o        <= 1'b0;
        end else begin
            state                <= next_state;
            tick_count           <= next_tick_count;
            conversion_busy_flag <= next_running;              // RQ14
            core_reset_o         <= (next_state == ST_ARM);    // RQ25
            core_sample_o        <= (next_state == ST_SAMPLE); // RQ22
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_high_byte <= RST_BYTE;
            result_low_byte  <= RST_BYTE;
        end else if (conv_done) begin
            result_high_byte <= fmt_hi; // RQ23 RQ24
            result_low_byte  <= fmt_lo; // RQ23
        end
    end

    // ********************************
    // registered analog and pad controls
    // ********************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adc_power_o     <= 1'b0;
            core_conv_clk_o <= 1'b0;
            mux_src_o       <= SRC_EXT;
            mux_ext_pin_o   <= RST_PINS;
            pin_analog_o    <= RST_PINS;
            pin_alt_en_o    <= RST_PINS;
            pin_gpio_en_o   <= ~RST_PINS;
            pin_pullup_en_o <= RST_PINS;
            pin_oe_b_o      <= ~RST_PINS;
        end else begin
            adc_power_o     <= power_enable; // RQ19
            core_conv_clk_o <= conv_tick;    // RQ17
            mux_src_o       <= src_dec;      // RQ2
            mux_ext_pin_o   <= ext_dec;      // RQ3 RQ5
            pin_analog_o    <= analog;
            pin_alt_en_o    <= alt_dec;      // RQ10
            pin_gpio_en_o   <= gpio_dec;     // RQ10
            pin_pullup_en_o <= pull_dec;     // RQ11
            pin_oe_b_o      <= oe_b_dec;     // RQ12
        end
    end

endmodule

// >>> dv/adcs_monitor.sv
// adcs_monitor: port assertions for adcs_top
`timescale 1ns/1ps
module adcs_monitor
    import adcs_pkg::*;
(
    input wire logic                ref_clk_i, rst_b_i, avs_read_i, avs_write_i,
    input wire logic                avs_waitrequest_o, core_reset_o, core_sample_o,
    input wire logic [NUM_PINS-1:0] pin_analog_o, pin_alt_en_o, pin_gpio_en_o,
    input wire logic [NUM_PINS-1:0] pin_pullup_en_o, pin_oe_b_o, mux_ext_pin_o,
    input wire adcs_src_t           mux_src_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_oe_override: assert property ((pin_oe_b_o & pin_analog_o) == pin_analog_o)
        else $error("analog pin driven");
    a_pullup_off: assert property ((pin_pullup_en_o & pin_analog_o) == 9'h000)
        else $error("pull-high on analog pin");
    a_other_off: assert property (((pin_alt_en_o | pin_gpio_en_o) & pin_analog_o) == 9'h000)
        else $error("other function on analog pin");
    a_int_no_pin: assert property (mux_src_o != SRC_EXT |-> mux_ext_pin_o == 9'h000)
        else $error("pin joined to internal source");
    a_pin_onehot: assert property ($onehot0(mux_ext_pin_o))
        else $error("several pins joined");
    a_reset_no_sample: assert property (core_reset_o |-> !core_sample_o)
        else $error("sampling while core in reset");
    a_bus_answer: assert property ((avs_read_i | avs_write_i) & avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no bus answer");
    a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low too long");
    c_sample: cover property ($rose(core_sample_o));
    c_ground: cover property (mux_src_o == SRC_GND);
    c_analog: cover property (|pin_analog_o);
endmodule
bind adcs_top adcs_monitor u_mon (.ref_clk_i, .rst_b_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .core_reset_o, .core_sample_o, .pin_analog_o, .pin_alt_en_o,
    .pin_gpio_en_o, .pin_pullup_en_o, .pin_oe_b_o, .mux_ext_pin_o, .mux_src_o);

// >>> dv/adcs_core_model.sv
// adcs_core_model: converter core giving a fresh result per conversion
`timescale 1ns/1ps
module adcs_core_model (
    input  wire logic        ref_clk_i,
    input  wire logic        core_reset_i,
    output logic      [11:0] result_o
);
    initial result_o = 12'h5A3;
    // new value while held in reset, steady while converting
    always @(posedge ref_clk_i) if (core_reset_i) result_o <= {result_o[10:0], result_o[7]} ^ 12'h3C1;
endmodule

// >>> dv/tb_top.sv
// tb_top: directed and random tests of adcs_top
`timescale 1ns/1ps
module tb_top;
    import adcs_pkg::*;
    logic        ref_clk_i = 0, rst_b_i = 0, avs_read_i = 0, avs_write_i = 0, core_conv_clk_o;
    logic [4:0]  avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, rdata, avs_readdata_o;
    logic [8:0]  port_dir_out_i = 0, port_pullup_i = 0, lo, hi, mux_ext_pin_o, pin_analog_o;
    logic [8:0]  pin_alt_en_o, pin_gpio_en_o, pin_pullup_en_o, pin_oe_b_o;
    logic [11:0] core_result_i;
    logic        avs_waitrequest_o, adc_power_o, core_reset_o, core_sample_o, adc_irq_o;
    adcs_src_t   mux_src_o;
    int          fail_count = 0, checks_done = 0, ticks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) ticks <= ticks + core_conv_clk_o;
    adcs_top DUT (.ref_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .port_dir_out_i,
        .port_pullup_i, .core_result_i, .adc_power_o, .core_reset_o, .core_sample_o,
        .core_conv_clk_o, .mux_src_o, .mux_ext_pin_o, .pin_analog_o, .pin_alt_en_o,
        .pin_gpio_en_o, .pin_pullup_en_o, .pin_oe_b_o, .adc_irq_o);
    adcs_core_model u_core (.ref_clk_i, .core_reset_i(core_reset_o), .result_o(core_result_i));
    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        rdata = avs_readdata_o;
        avs_write_i <= 0;
        avs_read_i <= 0;
    endtask
    function automatic logic [2:0] exp_src(input logic [3:0] s);
        if (s inside {[1:3], [5:7]}) return s[2:0];
        return (s[3:2] == 2'b10) ? 3'h4 : 3'h0;
    endfunction
    function automatic logic [8:0] exp_pin(input logic [3:0] s, c);
        return (exp_src(s) == 3'h0 && c <= 8 && c != 2) ? 9'h001 << c : 9'h000;
    endfunction
    task automatic conv(input logic [2:0] sel, input logic fmt, en);
        logic [11:0] d;
        logic [31:0] c0;
        time         t0;
        int          n0;
        c0 = {26'h0, 1'b1, fmt, 4'h0};
        acc(1, OFS_CTRL0, c0);
        acc(1, OFS_IRQ, {30'h0, en, 1'b1});
        acc(1, OFS_CTRL1, {29'h0, sel});
        acc(1, OFS_CTRL0, c0 | 32'h80);
        acc(1, OFS_CTRL0, c0);
        t0 = $time;
        n0 = ticks;
        acc(0, OFS_CTRL0, 0);
        d = core_result_i;
        chk(rdata, c0 | 32'h40);
        chk(adc_power_o, 1);
        if (en) begin
            while (adc_irq_o !== 1'b1 && $time - t0 < 30000) @(posedge ref_clk_i);
            chk(int'(($time - t0) / 10) inside {[(16 << sel):(16 << sel) + 3]}, 1);
        end else
            do acc(0, OFS_CTRL0, 0); while (rdata[6] !== 1'b0 && $time - t0 < 30000);
        acc(0, OFS_CTRL0, 0);
        chk(rdata, c0);
        chk(ticks - n0, 16);
        acc(0, OFS_RES_HI, 0);
        chk(rdata, fmt ? {28'h0, d[11:8]} : {24'h0, d[11:4]});
        acc(0, OFS_RES_LO, 0);
        chk(rdata, fmt ? {24'h0, d[7:0]} : {24'h0, d[3:0], 4'h0});
        acc(0, OFS_IRQ, 0);
        chk(rdata, {30'h0, en, 1'b1});
        chk(adc_irq_o, en);
        $display("test conversion done");
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        results;
    end
    initial begin
        void'($urandom(32'hB7D7));
        repeat (6) @(posedge ref_clk_i);
        rst_b_i <= 1;
        for (int a = 0; a < 32; a += 4) begin
            acc(0, 5'(a), 0);
            chk(rdata, 0);
        end
        acc(1, OFS_CTRL1, 32'hFF);
        acc(1, 5'h1C, 32'hFF);
        acc(1, OFS_RES_HI, 32'hFF);
        acc(0, OFS_CTRL1, 0);
        chk(rdata, 32'hF7);
        acc(0, 5'h1C, 0);
        chk(rdata, 0);
        acc(0, OFS_RES_HI, 0);
        chk(rdata, 0);
        $display("test registers done");
        for (int i = 0; i < 48; i++) begin
            acc(1, OFS_CTRL1, {24'h0, (i < 16) ? 4'h4 : 4'(i), 4'h0});
            acc(1, OFS_CTRL0, {28'h0, (i < 16) ? 4'(i) : 4'($urandom)});
            repeat (2) @(posedge ref_clk_i);
            chk(mux_src_o, exp_src((i < 16) ? 4'h4 : 4'(i)));
            chk(mux_ext_pin_o, exp_pin((i < 16) ? 4'h4 : 4'(i), avs_writedata_i[3:0]));
        end
        $display("test mux done");
        for (int i = 0; i < 10; i++) begin
            lo = i ? 9'($urandom) : 9'h1FF;
            hi = 9'($urandom);
            port_dir_out_i <= 9'($urandom);
            port_pullup_i <= 9'($urandom);
            acc(1, OFS_PIN_LO, {23'h0, lo});
            acc(1, OFS_PIN_HI, {23'h0, hi});
            repeat (2) @(posedge ref_clk_i);
            chk(pin_analog_o, lo);
            chk(pin_alt_en_o, ~lo & hi);
            chk(pin_gpio_en_o, 9'h1FF ^ (lo | hi));
            chk(pin_pullup_en_o, ~lo & port_pullup_i);
            chk(pin_oe_b_o, 9'h1FF ^ (~lo & port_dir_out_i));
        end
        $display("test pins done");
        for (int i = 0; i < 6; i++)
            conv(3'(i == 1 ? 7 : i < 4 ? i : $urandom | 6), i[0], i != 2);
        acc(0, OFS_RES_HI, 0);
        hi = rdata[8:0];
        acc(1, OFS_CTRL0, 32'hA0);
        acc(1, OFS_CTRL0, 32'h20);
        acc(1, OFS_CTRL0, 32'h00);
        repeat (40) @(posedge ref_clk_i);
        chk(adc_power_o, 0);
        acc(0, OFS_CTRL0, 0);
        chk(rdata, 0);
        acc(0, OFS_RES_HI, 0);
        chk(rdata, hi);
        acc(1, OFS_IRQ, 32'h1);
        acc(0, OFS_IRQ, 0);
        chk(rdata, 0);
        $display("test power done");
        results;
    end
endmodule
